// *** hw/charger_option_and_current_regs.sv ***
// option byte and charge current setpoint, reached over the two-wire host port
// assumes synchronous scl/sda samples and an external open-drain pad
// Operation
// - with audio avoid on, force a pulse-frequency cycle before 20 kHz would be crossed
// - rate select 0 is 800 kHz, 1 is 600 kHz; comes up as 1
// - mode-pin result updates the rate select once after power-on; then host only
// - setpoint code sits in bits 13-3, 8 mA a step with 5 milliohm
// - nonzero setpoint code below 010h acts as 010h (128 mA with 5 milliohm, 320 mA with 2 milliohm)
// - out-of-range write stores the limit; 5 milliohm tops at 7F8h
// - 2 milliohm sense clamps at 5DCh with 20 mA a step
// - overcurrent fault, zero voltage write, watchdog or safety timer zero the setpoint
// - battery removal or adapter loss zeroes the setpoint
// - charge state reaching 111b zeroes the setpoint
// - setpoint is 0000h after power-on, register reset and watchdog expiry
// - upper byte at odd subaddress 3, lower byte at even subaddress 2
`timescale 1ns/10ps
`default_nettype none
module charger_option_and_current_regs #(
  parameter int AUDIO_MAX_GAP = charger_regs_pkg::OOA_GAP_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      sclIn,
  input  wire logic                      sdaIn,
  output logic                           sdaOut,
  output logic                           sdaOe,
  input  wire logic                      senseResistorSelect,
  input  wire logic                      switchPulse,
  input  wire logic                      modeProgDone,
  input  wire logic                      modeRateSelect,
  input  wire logic                      regResetCmd,
  input  wire charger_regs_pkg::events_t events,
  output logic                           audioBandAvoidEnable,
  output logic                           switchingRateSelect,
  output logic                           batteryOvervoltageEnable,
  output logic                     [7:0] switchPeriodCycles,
  output logic                           pfmKick,
  output logic                    [10:0] chargeCurrentCode,
  output logic                    [15:0] chargeCurrentMa
);
  charger_regs_pkg::regs_t st;
  charger_regs_pkg::regs_t next_st;
  logic        zeroReq;
  logic [10:0] clampedCode;
  logic        wrEn;
  logic [7:0]  wrSub;
  logic [7:0]  wrData;
  logic        sclRise;
  logic        sclFall;
  logic        busStart;
  logic        busStop;
  logic [7:0]  rdByte;

  // byte seen by the host at a subaddress
  function automatic logic [7:0] read_byte(input logic [7:0] sub, input logic [7:0] opt, input logic [10:0] amps);
    logic [15:0] word;
    word = {2'h0, amps, 3'h0};
    unique case (sub)
      charger_regs_pkg::SUB_OPTIONS: read_byte = opt;
      charger_regs_pkg::SUB_AMPS_LO: read_byte = word[7:0];
      charger_regs_pkg::SUB_AMPS_HI: read_byte = word[15:8];
      default:                       read_byte = 8'h00;
    endcase
  endfunction

  charge_event_detect u_events (
    .core_clk (core_clk),
    .nrst     (nrst),
    .events   (events),
    .zeroReq  (zeroReq)
  );

  amps_clamp u_clamp (
    .wrWord              ({wrData, st.ampsLoStage}),
    .senseResistorSelect (senseResistorSelect),
    .code                (clampedCode)
  );

  // bus line conditions from the previous samples
  assign sclRise  = sclIn & ~st.sclD;
  assign sclFall  = ~sclIn & st.sclD;
  assign busStart = st.sclD & sclIn & st.sdaD & ~sdaIn;
  assign busStop  = st.sclD & sclIn & ~st.sdaD & sdaIn;
  assign rdByte   = read_byte(st.sub, st.options, st.amps);

  // serial slave, register updates and derived outputs
  always_comb begin
    next_st      = st;
    wrEn         = 1'b0;
    wrSub        = st.sub;
    wrData       = {st.shift[6:0], sdaIn};
    next_st.sclD = sclIn;
    next_st.sdaD = sdaIn;
    if (busStart) begin
      next_st.bus    = charger_regs_pkg::BUS_ADDR;
      next_st.bitCnt = 3'h0;
      next_st.sdaOe  = 1'b0;
    end else if (busStop) begin
      next_st.bus   = charger_regs_pkg::BUS_IDLE;
      next_st.sdaOe = 1'b0;
    end else begin
      unique case (st.bus)
        charger_regs_pkg::BUS_IDLE: begin
          next_st.sdaOe = 1'b0;
        end
        charger_regs_pkg::BUS_ADDR, charger_regs_pkg::BUS_SUB, charger_regs_pkg::BUS_WDATA: begin
          if (sclRise) begin
            next_st.shift  = wrData;
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
              unique case (st.bus)
                charger_regs_pkg::BUS_ADDR: begin
                  next_st.rw  = sdaIn;
                  next_st.bus = (st.shift[6:0] == charger_regs_pkg::DEV_ADDR) ?
                                charger_regs_pkg::BUS_ADDR_ACK : charger_regs_pkg::BUS_IDLE;
                end
                charger_regs_pkg::BUS_SUB: begin
                  next_st.sub = wrData;
                  next_st.bus = charger_regs_pkg::BUS_SUB_ACK;
                end
                default: begin
                  wrEn        = 1'b1;
                  next_st.bus = charger_regs_pkg::BUS_WACK;
                end
              endcase
            end
          end
        end
        charger_regs_pkg::BUS_ADDR_ACK, charger_regs_pkg::BUS_SUB_ACK, charger_regs_pkg::BUS_WACK: begin
          // pull low for one bit time, then hand the line back
          if (sclFall) begin
            if (!st.sdaOe) begin
              next_st.sdaOe = 1'b1;
            end else begin
              next_st.sdaOe  = 1'b0;
              next_st.bitCnt = 3'h0;
              if (st.bus == charger_regs_pkg::BUS_ADDR_ACK && st.rw) begin
                next_st.shift = rdByte;
                next_st.sdaOe = ~rdByte[7];
                next_st.bus   = charger_regs_pkg::BUS_RDATA;
              end else if (st.bus == charger_regs_pkg::BUS_ADDR_ACK) begin
                next_st.bus = charger_regs_pkg::BUS_SUB;
              end else begin
                if (st.bus == charger_regs_pkg::BUS_WACK) begin
                  next_st.sub = st.sub + 8'h01;
                end
                next_st.bus = charger_regs_pkg::BUS_WDATA;
              end
            end
          end
        end
        charger_regs_pkg::BUS_RDATA: begin
          if (sclRise) begin
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
              next_st.bus = charger_regs_pkg::BUS_RACK;
            end
          end else if (sclFall && st.bitCnt != 3'h0) begin
            next_st.shift = {st.shift[6:0], 1'b0};
            next_st.sdaOe = ~st.shift[6];
          end
        end
        charger_regs_pkg::BUS_RACK: begin
          // release for the host acknowledge, continue only on a low
          if (sclFall) begin
            next_st.sdaOe = 1'b0;
          end else if (sclRise) begin
            if (!sdaIn) begin
              next_st.sub = st.sub + 8'h01;
              next_st.bus = charger_regs_pkg::BUS_RLOAD;
            end else begin
              next_st.bus = charger_regs_pkg::BUS_IDLE;
            end
          end
        end
        charger_regs_pkg::BUS_RLOAD: begin
          if (sclFall) begin
            next_st.shift  = rdByte;
            next_st.sdaOe  = ~rdByte[7];
            next_st.bitCnt = 3'h0;
            next_st.bus    = charger_regs_pkg::BUS_RDATA;
          end
        end
        default: begin
          next_st.bus   = charger_regs_pkg::BUS_IDLE;
          next_st.sdaOe = 1'b0;
        end
      endcase
    end
    next_st.sdaOut = 1'b0;

    // rate select taken from the mode pins once per power-on
    if (!st.modeDone && modeProgDone) begin
      next_st.options[charger_regs_pkg::RATE_BIT] = modeRateSelect;
      next_st.modeDone = 1'b1;
    end

    // host writes; the high byte commits the staged low byte
    if (wrEn) begin
      unique case (wrSub)
        charger_regs_pkg::SUB_OPTIONS: next_st.options = wrData;
        charger_regs_pkg::SUB_AMPS_LO: next_st.ampsLoStage = wrData;
        charger_regs_pkg::SUB_AMPS_HI: next_st.amps = clampedCode;
        default: ;
      endcase
    end

    // register reset keeps the rate select, zero events override host writes and register reset of the setpoint
    if (regResetCmd) begin
      next_st.options = (charger_regs_pkg::OPTIONS_RESET & ~charger_regs_pkg::RATE_MASK)
                      | (next_st.options & charger_regs_pkg::RATE_MASK);
      next_st.amps        = charger_regs_pkg::AMPS_RESET[charger_regs_pkg::AMPS_MSB:charger_regs_pkg::AMPS_LSB];
      next_st.ampsLoStage = 8'h00;
    end
    if (zeroReq) begin
      next_st.amps = 11'h000;
    end

    // effective setpoint and its value in milliamps
    next_st.ampsEff = (st.amps != 11'h000 && st.amps < charger_regs_pkg::AMPS_MIN_CODE) ?
                      charger_regs_pkg::AMPS_MIN_CODE : st.amps;
    next_st.ampsMa  = 16'(next_st.ampsEff) * 16'(senseResistorSelect ? charger_regs_pkg::STEP_MA_2M
                                                                      : charger_regs_pkg::STEP_MA_5M);

    // switching period follows the rate select
    next_st.rateCycles = st.options[charger_regs_pkg::RATE_BIT] ?
                         charger_regs_pkg::SLOW_CYCLES : charger_regs_pkg::FAST_CYCLES;

    // gap timer forces a cycle before the audio floor is crossed
    next_st.pfmKick = 1'b0;
    if (switchPulse || st.pfmKick) begin
      next_st.gapCnt = 16'h0000;
    end else if (st.gapCnt != 16'(AUDIO_MAX_GAP - 1)) begin
      next_st.gapCnt = st.gapCnt + 16'h0001;
    end
    if (st.options[charger_regs_pkg::OOA_BIT] && !switchPulse && !st.pfmKick
        && st.gapCnt == 16'(AUDIO_MAX_GAP - 2)) begin
      next_st.pfmKick = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st         <= '0;
      st.bus     <= charger_regs_pkg::BUS_IDLE;
      st.sclD    <= 1'b1;
      st.sdaD    <= 1'b1;
      st.options <= charger_regs_pkg::OPTIONS_RESET;
      st.amps    <= charger_regs_pkg::AMPS_RESET[charger_regs_pkg::AMPS_MSB:charger_regs_pkg::AMPS_LSB];
      st.rateCycles <= charger_regs_pkg::SLOW_CYCLES;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign sdaOut                   = st.sdaOut;
  assign sdaOe                    = st.sdaOe;
  assign audioBandAvoidEnable     = st.options[charger_regs_pkg::OOA_BIT];
  assign switchingRateSelect      = st.options[charger_regs_pkg::RATE_BIT];
  assign batteryOvervoltageEnable = st.options[charger_regs_pkg::OVP_BIT];
  assign switchPeriodCycles       = st.rateCycles;
  assign pfmKick                  = st.pfmKick;
  assign chargeCurrentCode        = st.ampsEff;
  assign chargeCurrentMa          = st.ampsMa;

  // checks
  a_kick_needs_avoid: assert property (@(posedge core_clk) disable iff (!nrst)
    st.pfmKick |-> $past(st.options[charger_regs_pkg::OOA_BIT])) else $error("kick without audio avoid");
  a_gap_bounded: assert property (@(posedge core_clk) disable iff (!nrst)
    st.options[charger_regs_pkg::OOA_BIT] && st.gapCnt == 16'(AUDIO_MAX_GAP - 2) && !switchPulse && !st.pfmKick
    |=> st.pfmKick) else $error("audio gap overrun");
  a_rate_period: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 st.rateCycles == ($past(st.options[charger_regs_pkg::RATE_BIT]) ? charger_regs_pkg::SLOW_CYCLES
                                                                       : charger_regs_pkg::FAST_CYCLES))
    else $error("switching period mismatch");
  a_mode_once: assert property (@(posedge core_clk) disable iff (!nrst)
    st.modeDone && modeProgDone && !wrEn |=> $stable(st.options[charger_regs_pkg::RATE_BIT]))
    else $error("mode pins changed rate twice");
  a_mode_apply: assert property (@(posedge core_clk) disable iff (!nrst)
    !st.modeDone && modeProgDone && !wrEn |=> st.modeDone && st.options[charger_regs_pkg::RATE_BIT] == $past(modeRateSelect))
    else $error("mode pin rate not applied");
  a_amps_clamp: assert property (@(posedge core_clk) disable iff (!nrst)
    wrEn && wrSub == charger_regs_pkg::SUB_AMPS_HI |=>
    st.amps <= ($past(senseResistorSelect) ? charger_regs_pkg::AMPS_MAX_2M : charger_regs_pkg::AMPS_MAX_5M))
    else $error("charge current above clamp");
  a_amps_min: assert property (@(posedge core_clk) disable iff (!nrst)
    st.amps != 11'h000 |=> st.ampsEff >= charger_regs_pkg::AMPS_MIN_CODE) else $error("setpoint below floor");
  a_zero_event: assert property (@(posedge core_clk) disable iff (!nrst)
    zeroReq |=> st.amps == 11'h000 ##1 st.ampsEff == 11'h000) else $error("event did not zero setpoint");
  a_reg_reset: assert property (@(posedge core_clk) disable iff (!nrst)
    regResetCmd |=> st.amps == 11'h000 && st.options[charger_regs_pkg::OOA_BIT]) else $error("register reset missed");
  a_ma_scale: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 st.ampsMa == 16'(st.ampsEff) * 16'($past(senseResistorSelect) ? charger_regs_pkg::STEP_MA_2M
                                                                       : charger_regs_pkg::STEP_MA_5M))
    else $error("milliamp scaling wrong");
  a_stop_release: assert property (@(posedge core_clk) disable iff (!nrst)
    busStop |=> !st.sdaOe) else $error("data line held after stop");
  a_floor_exact: assert property (@(posedge core_clk) disable iff (!nrst)
    st.amps != 11'h000 && st.amps < charger_regs_pkg::AMPS_MIN_CODE |=> st.ampsEff == charger_regs_pkg::AMPS_MIN_CODE)
    else $error("small setpoint not raised to floor");
  a_removal_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(events.batteryPresentInput) || $fell(events.adapterValidStatus) |=> st.amps == 11'h000)
    else $error("removal did not zero setpoint");
  a_term_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    events.chargeStateField == charger_regs_pkg::CHG_TERMINATED
    && $past(events.chargeStateField) != charger_regs_pkg::CHG_TERMINATED |=> st.amps == 11'h000)
    else $error("termination did not zero setpoint");
endmodule // charger_option_and_current_regs
`default_nettype wire

// *** hw/charger_regs_pkg.sv ***
// constants, types and state records for the charger option and charge current registers
// assumes a 100 MHz core clock and a two-wire serial host port on synchronous pins
package charger_regs_pkg;

  // bus address of this device; value is arbitrary
  localparam logic [6:0]  DEV_ADDR       = 7'h09;
  // byte subaddresses
  localparam logic [7:0]  SUB_OPTIONS    = 8'h01;
  localparam logic [7:0]  SUB_AMPS_LO    = 8'h02;
  localparam logic [7:0]  SUB_AMPS_HI    = 8'h03;
  // option byte layout and value after reset
  localparam logic [7:0]  OPTIONS_RESET  = 8'hE7;
  localparam int          OOA_BIT        = 2;
  localparam int          RATE_BIT       = 1;
  localparam int          OVP_BIT        = 0;
  localparam logic [7:0]  RATE_MASK      = 8'h02;
  // charge current register layout, codes and value after reset
  localparam int          AMPS_LSB       = 3;
  localparam int          AMPS_MSB       = 13;
  localparam logic [15:0] AMPS_RESET     = 16'h0000;
  localparam logic [10:0] AMPS_MIN_CODE  = 11'h010;
  localparam logic [10:0] AMPS_MAX_5M    = 11'h7F8;
  localparam logic [10:0] AMPS_MAX_2M    = 11'h5DC;
  localparam logic [4:0]  STEP_MA_5M     = 5'h08;
  localparam logic [4:0]  STEP_MA_2M     = 5'h14;
  localparam logic [2:0]  CHG_TERMINATED = 3'h7;
  // timing: clock rate, audio floor and switching rates
  localparam int          CLK_KHZ        = 100000;
  localparam int          OOA_MIN_KHZ    = 20;
  localparam int          OOA_GAP_CYCLES = CLK_KHZ / OOA_MIN_KHZ - 1;  // one cycle short keeps the floor strictly above
  localparam int          RATE_FAST_KHZ  = 800;
  localparam int          RATE_SLOW_KHZ  = 600;
  localparam logic [7:0]  FAST_CYCLES    = 8'(CLK_KHZ / RATE_FAST_KHZ);
  localparam logic [7:0]  SLOW_CYCLES    = 8'(CLK_KHZ / RATE_SLOW_KHZ);

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_SUB, BUS_SUB_ACK,
    BUS_WDATA, BUS_WACK, BUS_RDATA, BUS_RACK, BUS_RLOAD
  } bus_state_t;

  // charger events that can zero the charge current
  typedef struct packed {
    logic       batteryChargeOvercurrentFault;
    logic       chargeVoltageZeroWrite;
    logic       watchdogExpired;
    logic       safetyTimerExpired;
    logic       batteryPresentInput;
    logic       adapterValidStatus;
    logic [2:0] chargeStateField;
  } events_t;

  // previous levels kept by the event detector
  typedef struct packed {
    logic       batteryPresent;
    logic       adapterValid;
    logic [2:0] chargeState;
  } edge_state_t;

  // whole state of the register block
  typedef struct packed {
    bus_state_t  bus;
    logic [2:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  sub;
    logic        rw;
    logic        sclD;
    logic        sdaD;
    logic        sdaOut;
    logic        sdaOe;
    logic [7:0]  ampsLoStage;
    logic [7:0]  options;
    logic [10:0] amps;
    logic [10:0] ampsEff;
    logic [15:0] ampsMa;
    logic        modeDone;
    logic [15:0] gapCnt;
    logic        pfmKick;
    logic [7:0]  rateCycles;
  } regs_t;

endpackage

// *** hw/charge_event_detect.sv ***
// edge detector for the events that zero the charge current
// assumes event inputs are synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module charge_event_detect (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire charger_regs_pkg::events_t events,
  output logic                           zeroReq
);
  charger_regs_pkg::edge_state_t st;
  charger_regs_pkg::edge_state_t next_st;

  // remember last levels
  always_comb begin
    next_st.batteryPresent = events.batteryPresentInput;
    next_st.adapterValid   = events.adapterValidStatus;
    next_st.chargeState    = events.chargeStateField;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // fault pulses, removal edges and termination entry
  always_comb begin
    zeroReq = events.batteryChargeOvercurrentFault | events.chargeVoltageZeroWrite
            | events.watchdogExpired | events.safetyTimerExpired
            | (st.batteryPresent & ~events.batteryPresentInput)
            | (st.adapterValid & ~events.adapterValidStatus)
            | ((events.chargeStateField == charger_regs_pkg::CHG_TERMINATED)
               && (st.chargeState != charger_regs_pkg::CHG_TERMINATED));
  end
endmodule // charge_event_detect
`default_nettype wire

// *** hw/amps_clamp.sv ***
// clamps a written charge current word to the range of the chosen sense resistor
// purely combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none
module amps_clamp (
  input  wire logic [15:0] wrWord,
  input  wire logic        senseResistorSelect,
  output logic      [10:0] code
);
  logic [10:0] limit;
  logic [10:0] raw;

  // reserved bits dropped, value held at the high limit
  always_comb begin
    raw   = wrWord[charger_regs_pkg::AMPS_MSB:charger_regs_pkg::AMPS_LSB];
    limit = senseResistorSelect ? charger_regs_pkg::AMPS_MAX_2M : charger_regs_pkg::AMPS_MAX_5M;
    code  = (raw > limit) ? limit : raw;
  end
endmodule // amps_clamp
`default_nettype wire

// *** tb/i2c_host_model.sv ***
// host controller model for the two-wire register port, pull-up on the data line
// assumes it alone drives the serial clock; pins move only at falling core_clk edges
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  input  wire logic core_clk,
  input  wire logic sdaOut,
  input  wire logic sdaOe,
  output logic      sclIn,
  output logic      sdaIn
);
  logic sdaHost;
  // wired-and of both drivers; a released line floats up to 1
  assign sdaIn = sdaHost & ~(sdaOe & ~sdaOut);
  initial begin
    sclIn = 1'b1;
    sdaHost = 1'b1;
  end
  // set both pins and hold them for four core cycles
  task automatic step(input logic c, input logic d);
    sclIn = c;
    sdaHost = d;
    repeat (4) @(negedge core_clk);
  endtask
  // one bit: data moves while the clock is low, sampled at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    step(1'b0, sdaHost);
    step(1'b0, b);
    step(1'b1, b);
    r = sdaIn;
  endtask
  // start (1 then 0) or stop (0 then 1) with the clock high
  task automatic cond(input logic a, input logic b);
    logic r;
    bitx(a, r);
    step(1'b1, b);
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic ackIn, output logic [7:0] q, output logic nack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ackIn, nack);
  endtask
  // write one byte, or low then high byte of a word
  task automatic wr(input logic [7:0] addr, input logic [7:0] sub, input logic [15:0] w, input logic two,
                    output logic nack);
    logic [7:0] q;
    logic       n0;
    logic       n1;
    logic       n2;
    logic       n3;
    cond(1'b1, 1'b0);
    xbyte(addr, 1'b1, q, n0);
    xbyte(sub, 1'b1, q, n1);
    xbyte(w[7:0], 1'b1, q, n2);
    n3 = 1'b0;
    if (two) xbyte(w[15:8], 1'b1, q, n3);
    cond(1'b0, 1'b1);
    nack = n0 | n1 | n2 | n3;
  endtask
  // read two bytes from sub and sub+1 after a repeated start
  task automatic rd(input logic [7:0] sub, output logic [15:0] v);
    logic [7:0] q;
    logic       n;
    cond(1'b1, 1'b0);
    xbyte({charger_regs_pkg::DEV_ADDR, 1'b0}, 1'b1, q, n);
    xbyte(sub, 1'b1, q, n);
    cond(1'b1, 1'b0);
    xbyte({charger_regs_pkg::DEV_ADDR, 1'b1}, 1'b1, q, n);
    xbyte(8'hFF, 1'b0, v[7:0], n);
    xbyte(8'hFF, 1'b1, v[15:8], n);
    cond(1'b0, 1'b1);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the option byte and charge current registers
// assumes the host model drives the serial pins; other inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int                        GAP  = 20;
  localparam int                        LIMIT = 60000;
  localparam logic [7:0]                WR   = {charger_regs_pkg::DEV_ADDR, 1'b0};
  localparam logic [7:0]                SUBO = charger_regs_pkg::SUB_OPTIONS;
  localparam logic [7:0]                SUBA = charger_regs_pkg::SUB_AMPS_LO;
  localparam charger_regs_pkg::events_t IDLE = 9'h018;
  logic                      core_clk;
  logic                      nrst;
  logic                      sclIn;
  logic                      sdaIn;
  logic                      sdaOut;
  logic                      sdaOe;
  logic                      senseResistorSelect;
  logic                      switchPulse;
  logic                      modeProgDone;
  logic                      modeRateSelect;
  logic                      regResetCmd;
  charger_regs_pkg::events_t events;
  logic                      audioBandAvoidEnable;
  logic                      switchingRateSelect;
  logic                      batteryOvervoltageEnable;
  logic                [7:0] switchPeriodCycles;
  logic                      pfmKick;
  logic               [10:0] chargeCurrentCode;
  logic               [15:0] chargeCurrentMa;
  logic               [15:0] v;
  logic                      nack;
  int                        err_count;
  int                        check_count;
  int                        cycles;
  charger_option_and_current_regs #(.AUDIO_MAX_GAP(GAP)) DUT (
    .core_clk, .nrst, .sclIn, .sdaIn, .sdaOut, .sdaOe, .senseResistorSelect, .switchPulse, .modeProgDone,
    .modeRateSelect, .regResetCmd, .events, .audioBandAvoidEnable, .switchingRateSelect,
    .batteryOvervoltageEnable, .switchPeriodCycles, .pfmKick, .chargeCurrentCode, .chargeCurrentMa);
  i2c_host_model host (.core_clk, .sdaOut, .sdaOe, .sclIn, .sdaIn);
  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      final_report;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chkBit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // power-on values seen over the bus and at the outputs
  task automatic t_reset;
    host.rd(SUBO, v);
    chkVal("options", 16'h00E7, v);
    chkVal("period", 16'h00A6, {8'h00, switchPeriodCycles});
    chkVal("amps ma", 16'h0000, chargeCurrentMa);
  endtask
  // mode pins set the rate once; afterwards only the host does
  task automatic t_mode;
    for (int i = 0; i < 2; i++) begin
      modeRateSelect = i[0];
      tick(1);
      modeProgDone = 1'b1;
      tick(1);
      modeProgDone = 1'b0;
      tick(3);
      chkBit("rate", 1'b0, switchingRateSelect);
    end
    chkVal("period", 16'h007D, {8'h00, switchPeriodCycles});
    host.wr(WR, SUBO, 16'h00E7, 1'b0, nack);
    chkBit("ack", 1'b0, nack);
    chkBit("rate", 1'b1, switchingRateSelect);
  endtask
  // falling edges until the next kick, giving up at 100
  task automatic waitKick(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (pfmKick !== 1'b1 && n < 100);
  endtask
  // kicks every GAP cycles with audio avoid on, none with it off
  task automatic t_audio;
    int n;
    waitKick(n);
    waitKick(n);
    chkVal("kick gap", 16'(GAP), 16'(n));
    tick(5);
    switchPulse = 1'b1;
    tick(1);
    switchPulse = 1'b0;
    waitKick(n);
    chkVal("kick after pulse", 16'(GAP - 1), 16'(n));
    host.wr(WR, SUBO, 16'h00E3, 1'b0, nack);
    chkBit("avoid", 1'b0, audioBandAvoidEnable);
    waitKick(n);
    chkVal("kick gap", 16'h0064, 16'(n));
  endtask
  // setpoint scaling, floor, clamps and reserved bits
  task automatic t_amps;
    logic [15:0] wd [6] = '{16'h0080, 16'h0008, 16'h1230, 16'hFFFF, 16'h3FF8, 16'h0000};
    logic [10:0] ec [6] = '{11'h010, 11'h001, 11'h246, 11'h7F8, 11'h5DC, 11'h000};
    logic [10:0] eff;
    for (int i = 0; i < 6; i++) begin
      senseResistorSelect = (i > 3);
      host.wr(WR, SUBA, wd[i], 1'b1, nack);
      host.rd(SUBA, v);
      chkVal("amps reg", {2'b00, ec[i], 3'b000}, v);
      eff = (ec[i] != 11'h000 && ec[i] < 11'h010) ? 11'h010 : ec[i];
      chkVal("amps code", {5'h00, eff}, {5'h00, chargeCurrentCode});
      chkVal("amps ma", 16'(eff * (i > 3 ? 20 : 8)), chargeCurrentMa);
    end
  endtask
  // every zeroing event, then register reset and a foreign address
  task automatic t_zero;
    logic [8:0] mk [7] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h007};
    host.wr(WR, SUBO, 16'h0000, 1'b0, nack);
    chkBit("ovp", 1'b0, batteryOvervoltageEnable);
    for (int i = 0; i < 8; i++) begin
      host.wr(WR, SUBA, 16'h0080, 1'b1, nack);
      chkVal("amps code", 16'h0010, {5'h00, chargeCurrentCode});
      if (i < 7) events = IDLE ^ mk[i];
      regResetCmd = (i == 7);
      tick(1);
      events = IDLE;
      regResetCmd = 1'b0;
      tick(3);
      chkVal("amps code", 16'h0000, {5'h00, chargeCurrentCode});
    end
    host.rd(SUBO, v);
    chkVal("options", 16'h00E5, v);
    chkBit("ovp", 1'b1, batteryOvervoltageEnable);
    host.wr(8'h14, SUBA, 16'h0080, 1'b1, nack);
    chkBit("nack", 1'b1, nack);
    chkVal("amps ma", 16'h0000, chargeCurrentMa);
  endtask
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    senseResistorSelect = 1'b0;
    switchPulse = 1'b0;
    modeProgDone = 1'b0;
    modeRateSelect = 1'b0;
    regResetCmd = 1'b0;
    events = IDLE;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    tick(3);
    nrst = 1'b1;
    tick(3);
    t_reset;
    t_mode;
    t_audio;
    t_amps;
    t_zero;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
